// ===== design/serial_port_cfg.svh
// constants for the four-wire serial register port
// assumes inclusion by bare name from every design file that needs it
// Overview of operation
// - a write frame is at least 40 serial clocks with the select held low; clocks past the 40th are ignored
// - host changes input on falling edges, device samples on rising edges
// - first 30 bits are the payload, MSB first, one per rising edge
// - next 7 bits are the register index, MSB first, sampled on rising edges
// - last 3 bits are the chip code; this device answers only to 111b
// - select rises after the 40th edge; payload is committed on that rise
// - every read frame also writes its payload to the addressed register, except to registers other than 0 while soft clear is held
// - device changes output on rising edges, host samples on falling edges
// - output floats unless the previous frame addressed this device
// - writing 80h to register 0 asserts soft clear, 00h releases it
// - after power-up all registers return to defaults within about 250 us
// - retrieval frame shifts 40 bits out: payload, index, chip code, MSB first
// - register 0 bits 6 to 0 hold the index returned in the next frame
`ifndef SERIAL_PORT_CFG_SVH
`define SERIAL_PORT_CFG_SVH

`define FRAME_BITS 40
`define PAYLOAD_BITS 30
`define INDEX_BITS 7
`define CHIP_BITS 3
`define OWN_CHIP_CODE 3'h7
`define CTRL_INDEX 7'h00
`define CTRL_READ_IDX_LSB 0
`define CTRL_CLEAR_BIT 7
`define CTRL_ID_LSB 8
`define CLK_MHZ 100
`define POR_TIME_US 250
`define POR_CYCLES (`POR_TIME_US * `CLK_MHZ)
`define MAX_SCLK_MHZ 30

`endif

// ===== design/serial_port_pkg.sv
// types shared by the serial register port
// assumes nothing of its surroundings
package serial_port_pkg;
  typedef logic [29:0] payload_t;
  typedef logic [6:0] reg_index_t;
  typedef logic [39:0] frame_t;
  typedef enum logic [0:0] {PWR_WAIT, RUN} power_state_e;
endpackage

// ===== design/pin_sync.sv
// two-flop synchroniser for a group of asynchronous pins
// assumes pins are slow against clock; only the second stage is exported
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // pins and synchronised copy
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinSync
);
  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      stage1_r <= '0;
      stage2_r <= '0;
    end else begin
      stage1_r <= pinIn;
      stage2_r <= stage1_r;
    end
  end

  assign pinSync = stage2_r;
endmodule
`default_nettype wire

// ===== design/serial_port_register_access.sv
// serial register port: 40-bit frames, register file, readback, soft clear
// assumes serial pins are asynchronous and far slower than clock
`timescale 1ns/100ps
`default_nettype none
`include "serial_port_cfg.svh"
module serial_port_register_access #(
  parameter int REG_COUNT = 32,
  parameter int POR_CYCLES = `POR_CYCLES,
  // arbitrary identity value
  parameter logic [21:0] CHIP_ID = 22'h0a5a5a
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // serial pins
  input wire logic serialClk,
  input wire logic port_select_n,
  input wire logic serialIn,
  output logic serialOut,
  output logic serialOutEn,
  // register write notification
  output logic writeStrobe,
  output serial_port_pkg::reg_index_t writeIndex,
  output serial_port_pkg::payload_t writeData,
  // status
  output logic software_clear,
  output logic powerReady
);
  localparam int CNT_W = 6;
  localparam int PORW = $clog2(POR_CYCLES + 1);

  logic [2:0] pinSync;
  logic sclkPrev_r;
  logic selPrev_r;
  logic sclkRise;
  logic selRise;

  // select enters inverted so the synchroniser's reset value is the idle level
  pin_sync #(.WIDTH(3)) u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .pinIn({serialClk, ~port_select_n, serialIn}),
    .pinSync(pinSync)
  );

  // rising clock with select low is the only sampling point
  assign sclkRise = pinSync[2] & ~sclkPrev_r & pinSync[1];
  assign selRise = ~pinSync[1] & selPrev_r;

  // register 0 keeps 8 bits; upper bits read back the identity
  function automatic serial_port_pkg::payload_t readWord(
    input serial_port_pkg::reg_index_t idx,
    input serial_port_pkg::payload_t word
  );
    if (idx == `CTRL_INDEX)
      readWord = {CHIP_ID, word[7:0]};
    else if (int'(idx) < REG_COUNT)
      readWord = word;
    else
      readWord = '0;
  endfunction

  // frame receive and readback state
  serial_port_pkg::frame_t rxShift_r, rxShift_nxt;
  serial_port_pkg::frame_t txShift_r, txShift_nxt;
  logic [CNT_W-1:0] bitCount_r, bitCount_nxt;
  logic readArmed_r, readArmed_nxt;
  logic serialOut_r, serialOut_nxt;
  logic serialOutEn_r, serialOutEn_nxt;
  logic writeStrobe_r, writeStrobe_nxt;
  serial_port_pkg::reg_index_t writeIndex_r, writeIndex_nxt;
  serial_port_pkg::payload_t writeData_r, writeData_nxt;
  logic frameValid;
  serial_port_pkg::reg_index_t rxIndex;
  serial_port_pkg::payload_t rxPayload;

  // register file and power-up state
  serial_port_pkg::payload_t regs_r [REG_COUNT];
  serial_port_pkg::payload_t regs_nxt [REG_COUNT];
  serial_port_pkg::power_state_e power_r, power_nxt;
  logic [PORW-1:0] porCount_r, porCount_nxt;
  serial_port_pkg::reg_index_t readIdx;

  assign rxPayload = rxShift_r[39:10];
  assign rxIndex = rxShift_r[9:3];
  // short or foreign frames never commit; long frames commit their first 40 bits
  assign frameValid = (bitCount_r == CNT_W'(`FRAME_BITS))
    && (rxShift_r[2:0] == `OWN_CHIP_CODE) && (power_r == serial_port_pkg::RUN);
  assign readIdx = regs_r[0][`CTRL_READ_IDX_LSB +: `INDEX_BITS];
  serial_port_pkg::payload_t readVal;
  assign readVal = readWord(readIdx, regs_r[readIdx[4:0]]);

  always_comb begin
    rxShift_nxt = rxShift_r;
    txShift_nxt = txShift_r;
    bitCount_nxt = bitCount_r;
    readArmed_nxt = readArmed_r;
    serialOut_nxt = serialOut_r;
    serialOutEn_nxt = serialOutEn_r;
    writeStrobe_nxt = 1'b0;
    writeIndex_nxt = writeIndex_r;
    writeData_nxt = writeData_r;
    if (!pinSync[1]) begin
      bitCount_nxt = '0;
      serialOutEn_nxt = 1'b0;
      serialOut_nxt = 1'b0;
    end else if (sclkRise && bitCount_r < CNT_W'(`FRAME_BITS)) begin
      rxShift_nxt = {rxShift_r[38:0], pinSync[0]};
      bitCount_nxt = bitCount_r + CNT_W'(1);
      if (readArmed_r) begin
        serialOutEn_nxt = 1'b1;
        if (bitCount_r == '0) begin
          // first edge loads the whole answer and shows its MSB
          txShift_nxt = {readVal, readIdx, `OWN_CHIP_CODE};
          serialOut_nxt = readVal[29];
        end else begin
          txShift_nxt = {txShift_r[38:0], 1'b0};
          serialOut_nxt = txShift_r[38];
        end
      end
    end
    if (selRise) begin
      readArmed_nxt = frameValid;
      if (frameValid) begin
        writeStrobe_nxt = 1'b1;
        writeIndex_nxt = rxIndex;
        writeData_nxt = rxPayload;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < REG_COUNT; i++) begin
      regs_nxt[i] = regs_r[i];
    end
    power_nxt = power_r;
    porCount_nxt = porCount_r;
    unique case (power_r)
      serial_port_pkg::PWR_WAIT: begin
        // defaults are held until the power-up delay has run out
        for (int i = 0; i < REG_COUNT; i++) begin
          regs_nxt[i] = '0;
        end
        if (porCount_r == PORW'(POR_CYCLES - 1))
          power_nxt = serial_port_pkg::RUN;
        else
          porCount_nxt = porCount_r + PORW'(1);
      end
      serial_port_pkg::RUN: begin
        if (selRise && frameValid && int'(rxIndex) < REG_COUNT) begin
          if (rxIndex == `CTRL_INDEX) begin
            // clear bit set: everything else back to defaults
            if (rxPayload[`CTRL_CLEAR_BIT]) begin
              for (int i = 1; i < REG_COUNT; i++) begin
                regs_nxt[i] = '0;
              end
            end
            regs_nxt[0] = {22'h0, rxPayload[7:0]};
          end else if (!regs_r[0][`CTRL_CLEAR_BIT]) begin
            regs_nxt[rxIndex[4:0]] = rxPayload;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sclkPrev_r <= 1'b0;
      selPrev_r <= 1'b0;
      rxShift_r <= '0;
      txShift_r <= '0;
      bitCount_r <= '0;
      readArmed_r <= 1'b0;
      serialOut_r <= 1'b0;
      serialOutEn_r <= 1'b0;
      writeStrobe_r <= 1'b0;
      writeIndex_r <= '0;
      writeData_r <= '0;
    end else begin
      sclkPrev_r <= pinSync[2];
      selPrev_r <= pinSync[1];
      rxShift_r <= rxShift_nxt;
      txShift_r <= txShift_nxt;
      bitCount_r <= bitCount_nxt;
      readArmed_r <= readArmed_nxt;
      serialOut_r <= serialOut_nxt;
      serialOutEn_r <= serialOutEn_nxt;
      writeStrobe_r <= writeStrobe_nxt;
      writeIndex_r <= writeIndex_nxt;
      writeData_r <= writeData_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_r[i] <= '0;
      end
      power_r <= serial_port_pkg::PWR_WAIT;
      porCount_r <= '0;
    end else begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_r[i] <= regs_nxt[i];
      end
      power_r <= power_nxt;
      porCount_r <= porCount_nxt;
    end
  end

  // every output straight from a flop
  logic clear_r;
  logic ready_r;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      clear_r <= 1'b0;
      ready_r <= 1'b0;
    end else begin
      clear_r <= regs_r[0][`CTRL_CLEAR_BIT];
      ready_r <= (power_r == serial_port_pkg::RUN);
    end
  end

  assign serialOut = serialOut_r;
  assign serialOutEn = serialOutEn_r;
  assign writeStrobe = writeStrobe_r;
  assign writeIndex = writeIndex_r;
  assign writeData = writeData_r;
  assign software_clear = clear_r;
  assign powerReady = ready_r;
endmodule
`default_nettype wire

// ===== dv/serial_port_properties.sv
// checker on the serial register port pins
// assumes a bind to the port top; one clock domain
`timescale 1ns/100ps
`default_nettype none
module serial_port_properties (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // serial pins
  input wire logic serialClk,
  input wire logic port_select_n,
  input wire logic serialOut,
  input wire logic serialOutEn,
  // commit and status
  input wire logic writeStrobe,
  input wire serial_port_pkg::reg_index_t writeIndex,
  input wire serial_port_pkg::payload_t writeData,
  input wire logic software_clear,
  input wire logic powerReady
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence clearWrite;
    writeStrobe && writeIndex == 7'h00;
  endsequence
  strobe_pulse_a: assert property (writeStrobe |=> !writeStrobe)
    else $error("commit strobe wider than one cycle");
  strobe_window_a: assert property (writeStrobe |-> port_select_n && !$past(port_select_n, 8))
    else $error("commit strobe away from select rise");
  strobe_ready_a: assert property (writeStrobe |-> powerReady)
    else $error("commit before power-up delay");
  enable_frame_a: assert property (serialOutEn |-> !$past(port_select_n, 4))
    else $error("output driven outside a frame");
  out_rise_a: assert property (serialOutEn && $past(serialOutEn) && $changed(serialOut)
    |-> $past(serialClk, 3))
    else $error("output changed away from a clock rise");
  clear_mirror_a: assert property (clearWrite |-> ##[0:3] software_clear == writeData[7])
    else $error("soft clear does not follow register 0 bit 7");
  ready_holds_a: assert property (powerReady |=> powerReady)
    else $error("power ready dropped");
  commit_hold_a: assert property (!writeStrobe |-> $stable(writeIndex) && $stable(writeData))
    else $error("commit outputs moved without a strobe");
endmodule
`default_nettype wire

// ===== dv/serial_host_model.sv
// host side of the serial port: frames bits out, reads readback back
// assumes the 100 MHz bench clock; link half period is four clocks
`timescale 1ns/100ps
`default_nettype none
module serial_host_model (
  // clock
  input wire logic clock,
  // serial pins
  output logic serialClk,
  output logic port_select_n,
  output logic serialIn,
  input wire logic serialOut,
  input wire logic serialOutEn
);
  logic lastOut = 1'b0;
  initial begin
    serialClk = 1'b0;
    port_select_n = 1'b1;
    serialIn = 1'b0;
  end
  // 80 ns link period, well under the port's top rate
  task automatic halfBit();
    repeat (4) @(posedge clock);
  endtask
  // link clock stands low between frames
  task automatic frame(input serial_port_pkg::frame_t txBits, input int count,
                       output serial_port_pkg::frame_t rxBits);
    int i;
    rxBits = '0;
    port_select_n <= 1'b0;
    serialIn <= txBits[39];
    halfBit();
    for (i = 0; i < count; i++) begin
      serialClk <= 1'b1;
      halfBit();
      // read at the falling edge; undriven line shows the inverse of the last bit
      lastOut = serialOutEn ? serialOut : ~lastOut;
      rxBits = {rxBits[38:0], lastOut};
      serialClk <= 1'b0;
      if (i < 39) serialIn <= txBits[38 - i];
      halfBit();
    end
    port_select_n <= 1'b1;
    serialIn <= ~serialIn;
    repeat (8) @(posedge clock);
  endtask
endmodule
`default_nettype wire

// ===== dv/serial_port_register_access_tb.sv
// bench for the serial register port: write, readback, refusals, soft clear
// assumes checker and host model are compiled first
`timescale 1ns/100ps
`default_nettype none
module serial_port_register_access_tb;
  localparam int POR = 20;
  localparam logic [21:0] ID = 22'h013579; // arbitrary identity value
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic serialClk, port_select_n, serialIn, serialOut, serialOutEn, writeStrobe;
  logic software_clear, powerReady;
  serial_port_pkg::reg_index_t writeIndex;
  serial_port_pkg::payload_t writeData;
  serial_port_pkg::frame_t rx;
  int errors = 0;
  int comparisons = 0;
  int strobes = 0;
  int drives = 0;
  always #5 clock = ~clock;
  always @(posedge clock) if (writeStrobe === 1'b1) strobes++;
  always @(posedge clock) if (serialOutEn === 1'b1) drives++;
  serial_port_register_access #(.POR_CYCLES(POR), .CHIP_ID(ID)) i_dut (.clock, .sys_rst,
    .serialClk, .port_select_n, .serialIn, .serialOut, .serialOutEn, .writeStrobe,
    .writeIndex, .writeData, .software_clear, .powerReady);
  serial_host_model i_host (.clock, .serialClk, .port_select_n, .serialIn, .serialOut,
    .serialOutEn);
  task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic put(input serial_port_pkg::reg_index_t idx, input logic [29:0] data);
    i_host.frame({data, idx, 3'h7}, 40, rx);
  endtask
  // second frame rewrites register 0 with the same index, leaving state alone
  task automatic fetch(input serial_port_pkg::reg_index_t idx);
    put(7'h00, 30'(idx));
    put(7'h00, 30'(idx));
  endtask
  task automatic test_power();
    int n;
    check("powerReady low", 40'h0, 40'(powerReady));
    for (n = 0; n < POR + 8 && powerReady !== 1'b1; n++) @(posedge clock);
    check("power-up wait", 40'h1, 40'(n >= POR && powerReady === 1'b1));
    check("serialOutEn idle", 40'h0, 40'(serialOutEn));
  endtask
  task automatic test_write_read();
    int s;
    s = strobes;
    put(7'h05, 30'h2b3c4d5e);
    check("strobe count", 40'(s + 1), 40'(strobes));
    check("writeIndex", 40'h05, 40'(writeIndex));
    check("writeData", 40'h2b3c4d5e, 40'(writeData));
    fetch(7'h05);
    check("readback", {30'h2b3c4d5e, 7'h05, 3'h7}, rx);
    check("implied write", 40'h05, 40'({writeIndex, writeData}));
    fetch(7'h00);
    check("reg 0 readback", {ID, 8'h00, 7'h00, 3'h7}, rx);
  endtask
  task automatic test_refuse();
    int s;
    int d;
    s = strobes;
    i_host.frame({30'h1, 7'h05, 3'h6}, 40, rx);
    d = drives;
    i_host.frame({30'h2, 7'h05, 3'h7}, 39, rx);
    check("refused strobes", 40'(s), 40'(strobes));
    check("no drive after refusal", 40'(d), 40'(drives));
    fetch(7'h05);
    check("reg kept", {30'h2b3c4d5e, 7'h05, 3'h7}, rx);
  endtask
  task automatic test_clear();
    put(7'h00, 30'h80);
    check("clear set", 40'h1, 40'(software_clear));
    // a write while the clear is held must not land
    put(7'h05, 30'h1234);
    put(7'h00, 30'h00);
    check("clear released", 40'h0, 40'(software_clear));
    fetch(7'h05);
    check("reg defaulted", {30'h0, 7'h05, 3'h7}, rx);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    test_power();
    test_write_read();
    test_refuse();
    test_clear();
    report_and_stop();
  end
  // fourteen frames of about 330 clocks; three times that as margin
  initial begin
    #150000;
    errors++;
    report_and_stop();
  end
endmodule
bind serial_port_register_access serial_port_properties i_props (.clock, .sys_rst,
  .serialClk, .port_select_n, .serialOut, .serialOutEn, .writeStrobe, .writeIndex,
  .writeData, .software_clear, .powerReady);
`default_nettype wire
